// ==== bench/amc_host.sv ====
// host model driving the reset pin, trigger, strap and pair pins
`timescale 1ns/1ps
`default_nettype none
module amc_host (
  input  wire logic                core_clk,
  output var  logic                dev_reset_pin_n,
  output var  logic                conv_trigger,
  output var  amc_pkg::amc_strap_s strap_pins,
  output var  logic [2:0]          pair_select_pins
);
  // pins start low, so the device sits in reset until told otherwise
  initial begin
    dev_reset_pin_n = 1'b0;
    conv_trigger = 1'b0;
    strap_pins = '0;
    pair_select_pins = 3'h0;
  end

  //////////////////////////////////////////////////////////////////////
  // reset pulse of a given length; straps settle before the release
  task automatic pulse_reset(input int cycles, input amc_pkg::amc_strap_s s,
                             input logic [2:0] p);
    @(posedge core_clk);
    dev_reset_pin_n <= 1'b0;
    strap_pins <= s;
    pair_select_pins <= p;
    repeat (cycles) @(posedge core_clk);
    dev_reset_pin_n <= 1'b1;
    // settling wait, scaled down from the real power-up time
    repeat (10) @(posedge core_clk);
  endtask : pulse_reset

  // strap change outside reset; the device must ignore the latched part
  task automatic set_pins(input amc_pkg::amc_strap_s s);
    @(posedge core_clk);
    strap_pins <= s;
  endtask : set_pins

  // trigger held three cycles so the synchroniser always sees it
  task automatic trigger(input int gap);
    @(posedge core_clk);
    conv_trigger <= 1'b1;
    repeat (3) @(posedge core_clk);
    conv_trigger <= 1'b0;
    repeat (gap) @(posedge core_clk);
  endtask : trigger
endmodule : amc_host
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the mode and pin configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                core_clk;
  logic                reset_n;
  logic                dev_reset_pin_n;
  logic                conv_trigger;
  amc_pkg::amc_strap_s strap_pins;
  logic [2:0]          pair_select_pins;
  logic [3:0]          reg_addr;
  logic [15:0]         reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [15:0]         reg_rdata;
  logic                busy;
  logic                shutdown;
  logic                hw_mode;
  logic [1:0]          iface_type;
  logic [1:0]          analog_range;
  logic [2:0]          active_pair;
  logic                result_strobe;
  logic                access_refused;
  logic [15:0]         rd;
  logic                refused;
  int                  strobes;
  int                  falls;
  int                  busy_cyc;
  logic [2:0]          pair;
  int                  err_total;
  int                  checks_done;

  // short conversion keeps burst runs brief
  localparam int CONV = 8;
  amc_ctrl #(.CONV_CYCLES(CONV), .PAIR_COUNT(8)) u_amc_ctrl (
    .core_clk(core_clk), .reset_n(reset_n), .dev_reset_pin_n(dev_reset_pin_n),
    .conv_trigger(conv_trigger), .strap_pins(strap_pins),
    .pair_select_pins(pair_select_pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy),
    .shutdown(shutdown), .hw_mode(hw_mode), .iface_type(iface_type),
    .analog_range(analog_range), .active_pair(active_pair),
    .result_strobe(result_strobe), .access_refused(access_refused));

  amc_host u_amc_host (
    .core_clk(core_clk), .dev_reset_pin_n(dev_reset_pin_n),
    .conv_trigger(conv_trigger), .strap_pins(strap_pins),
    .pair_select_pins(pair_select_pins));

  //////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  function automatic amc_pkg::amc_strap_s mk(input logic [1:0] rng, input logic ifs,
                                             input logic bys, input logic brst);
    amc_pkg::amc_strap_s s;
    s = '0;
    s.range_mode = rng;
    s.iface_sel = ifs;
    s.byte_sel = bys;
    s.burst_wr = brst;
    return s;
  endfunction : mk

  //////////////////////////////////////////////////////////////////////
  // register port: one-cycle strobes, answer in the following cycle
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d, output logic r);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1 r = access_refused;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d, output logic r);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    r = access_refused;
  endtask : reg_read

  // counts result pulses, busy cycles and busy falls over a fixed window
  task automatic watch(input int n);
    logic prev;
    strobes = 0;
    falls = 0;
    busy_cyc = 0;
    prev = 1'b0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (result_strobe === 1'b1) strobes++;
      if (busy === 1'b1) busy_cyc++;
      if (prev === 1'b1 && busy === 1'b0) falls++;
      if (busy === 1'b1 && prev !== 1'b1) pair = active_pair;
      prev = busy;
    end
  endtask : watch

  //////////////////////////////////////////////////////////////////////
  // software serial, single-wire strap; host leaves the second output open
  task automatic scen_sw_regs();
    amc_pkg::amc_strap_s s;
    s = mk(2'h0, 1'b1, 1'b0, 1'b0);
    s.single_wire = 1'b1;
    u_amc_host.pulse_reset(40, s, 3'h0);
    check(16'(shutdown), 16'h0000);
    check(16'(hw_mode), 16'h0000);
    check(16'(iface_type), 16'h0001);
    reg_write(amc_pkg::ADDR_CTRL, 16'h0300, refused);
    check(16'(refused), 16'h0000);
    reg_read(amc_pkg::ADDR_CTRL, rd, refused);
    check(rd, 16'h0300);
    reg_write(amc_pkg::ADDR_SCRATCH, 16'ha5c3, refused);
    reg_read(amc_pkg::ADDR_SCRATCH, rd, refused);
    check(rd, 16'ha5c3);
    reg_read(4'h9, rd, refused);
    check(rd, 16'h0000);
    reg_read(amc_pkg::ADDR_CONFIG, rd, refused);
    check(rd, 16'h000a);
  endtask : scen_sw_regs

  // second trigger lands while busy and must be dropped; pass 1 oversamples x2
  task automatic scen_sw_conv();
    for (int k = 0; k < 2; k++) begin
      if (k == 1) reg_write(amc_pkg::ADDR_CTRL, 16'h0311, refused);
      fork
        begin
          u_amc_host.trigger(2);
          u_amc_host.trigger(0);
        end
        watch(60);
      join
      check(16'(strobes), 16'h0001);
      check(16'(falls), 16'h0001);
      check(16'(pair), 16'h0003);
      check(16'(busy_cyc), 16'(CONV << k));
    end
    // sequencer mode steps to the next pair after its result
    check(16'(active_pair), 16'h0004);
  endtask : scen_sw_conv

  // short pulse keeps register contents
  task automatic scen_partial();
    u_amc_host.pulse_reset(5, mk(2'h0, 1'b1, 1'b0, 1'b0), 3'h0);
    reg_read(amc_pkg::ADDR_CTRL, rd, refused);
    check(rd, 16'h0311);
  endtask : scen_partial

  task automatic scen_shutdown();
    fork
      u_amc_host.pulse_reset(40, mk(2'h0, 1'b1, 1'b1, 1'b0), 3'h0);
      begin
        repeat (38) @(posedge core_clk);
        #1 check(16'(shutdown), 16'h0001);
      end
    join
    check(16'(iface_type), 16'h0003);
    reg_read(amc_pkg::ADDR_CTRL, rd, refused);
    check(rd, 16'h0000);
    reg_read(amc_pkg::ADDR_SCRATCH, rd, refused);
    check(rd, 16'h0000);
  endtask : scen_shutdown

  // hardware mode: straps latched, burst over pairs 0..2, registers shut
  task automatic scen_hw();
    u_amc_host.pulse_reset(40, mk(2'h2, 1'b0, 1'b0, 1'b1), 3'h2);
    check(16'(hw_mode), 16'h0001);
    check(16'(iface_type), 16'h0000);
    check(16'(analog_range), 16'h0002);
    reg_write(amc_pkg::ADDR_SCRATCH, 16'h1234, refused);
    check(16'(refused), 16'h0001);
    reg_read(amc_pkg::ADDR_SCRATCH, rd, refused);
    check(rd, 16'h0000);
    check(16'(refused), 16'h0001);
    for (int k = 0; k < 2; k++) begin
      fork
        u_amc_host.trigger(0);
        watch(100);
      join
      check(16'(strobes), 16'h0003);
      check(16'(falls), 16'h0001);
      check(16'(pair), 16'h0000);
      // later strap changes must not reach the latched set
      u_amc_host.set_pins(mk(2'h1, 1'b1, 1'b0, 1'b0));
      repeat (6) @(posedge core_clk);
      #1 check(16'(iface_type), 16'h0000);
      check(16'(hw_mode), 16'h0001);
      check(16'(analog_range), 16'h0001);
    end
    // status stays readable: last burst pair 2, hardware mode, idle
    reg_read(amc_pkg::ADDR_STATUS, rd, refused);
    check(rd, 16'h0028);
    check(16'(refused), 16'h0001);
  endtask : scen_hw

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pair = 3'h0;
    err_total = 0;
    checks_done = 0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    #1 check(16'(shutdown), 16'h0001);
    scen_sw_regs();
    scen_sw_conv();
    scen_partial();
    scen_shutdown();
    scen_hw();
    test_done();
  end
endmodule : tb
`default_nettype wire

// ==== hw/amc_ctrl.sv ====
// converter mode, shutdown, strap latch and conversion control
`timescale 1ns/1ps
`default_nettype none
module amc_ctrl #(
  parameter int CONV_CYCLES = amc_pkg::CONV_CYCLES,
  parameter int PAIR_COUNT  = amc_pkg::PAIR_COUNT
) (
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  input  wire logic                dev_reset_pin_n,
  input  wire logic                conv_trigger,
  input  wire amc_pkg::amc_strap_s strap_pins,
  input  wire logic [2:0]          pair_select_pins,
  input  wire logic [3:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output var  logic [15:0]         reg_rdata,
  output var  logic                busy,
  output var  logic                shutdown,
  output var  logic                hw_mode,
  output var  logic [1:0]          iface_type,
  output var  logic [1:0]          analog_range,
  output var  logic [2:0]          active_pair,
  output var  logic                result_strobe,
  output var  logic                access_refused
);
  // elaboration checks: 8-bit cycle counter, 3-bit pair index
  if (CONV_CYCLES < 1 || CONV_CYCLES > 255) begin : g_bad_conv
    $error("CONV_CYCLES out of range");
  end
  if (PAIR_COUNT != 8) begin : g_bad_pairs
    $error("PAIR_COUNT must be 8");
  end

  typedef enum logic [1:0] {
    AMC_IDLE = 2'b00,
    AMC_CONV = 2'b01,
    AMC_DONE = 2'b11
  } amc_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int SW = $bits(amc_pkg::amc_strap_s) + 5;
  logic [SW-1:0] sync_q;
  amc_pkg::amc_strap_s strap_s;
  logic [2:0] pair_s;
  logic       trig_s;
  logic       rst_pin_s;

  amc_sync #(.WIDTH(SW)) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in ({strap_pins, pair_select_pins, conv_trigger, dev_reset_pin_n}),
    .sync_out (sync_q)
  );
  assign {strap_s, pair_s, trig_s, rst_pin_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // reset pulse width measurement
  logic [5:0] low_cnt;
  logic       rst_pin_q;
  logic       trig_q;
  wire        pin_rise    = rst_pin_s && !rst_pin_q;
  wire        long_low    = low_cnt >= 6'(amc_pkg::FULL_RESET_CYCLES);
  wire        full_rel    = pin_rise && shutdown;
  wire        partial_rel = pin_rise && !shutdown
                            && low_cnt >= 6'(amc_pkg::PARTIAL_MIN_CYCLES);
  wire        enter_sd    = !rst_pin_s && long_low && !shutdown;

  // count low time, saturating
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt   <= '0;
      rst_pin_q <= 1'b0;
      trig_q    <= 1'b0;
    end else begin
      rst_pin_q <= rst_pin_s;
      trig_q    <= trig_s;
      if (rst_pin_s)
        low_cnt <= '0;
      else if (!long_low)
        low_cnt <= low_cnt + 6'h01;
    end
  end

  // shutdown held from the 1.2 us mark until the pin rises; starts in shutdown
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      shutdown <= 1'b1;
    else if (enter_sd)
      shutdown <= 1'b1;
    else if (full_rel)
      shutdown <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap latch at full reset release
  amc_pkg::amc_cfg_s cfg;
  amc_pkg::amc_cfg_s next_cfg;
  logic [15:0] ctrl_reg;
  logic [15:0] scratch;
  wire         strap_hw = strap_s.range_mode != 2'h0;
  wire [1:0]   strap_if = {strap_s.iface_sel & strap_s.byte_sel, strap_s.iface_sel};

  always_comb begin
    next_cfg              = cfg;
    next_cfg.hw_mode      = strap_hw;
    next_cfg.iface        = amc_pkg::amc_iface_e'(strap_if);
    next_cfg.single_wire  = strap_s.single_wire;
    next_cfg.ref_internal = strap_s.ref_sel;
    next_cfg.check_code   = strap_hw & strap_s.check_code;
    next_cfg.burst        = strap_hw & strap_s.burst_wr;
    next_cfg.sequencer    = strap_hw & strap_s.sequencer;
    next_cfg.osr          = strap_hw ? strap_s.osr : 3'h0;
  end

  // latched only at full release; fixed otherwise
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      cfg <= '0;
    else if (full_rel)
      cfg <= next_cfg;
  end

  // effective settings: pins in hardware mode, registers in software mode
  wire       eff_burst = cfg.hw_mode ? cfg.burst : ctrl_reg[amc_pkg::CTRL_BURST_BIT];
  wire       eff_seq   = cfg.hw_mode ? cfg.sequencer : ctrl_reg[amc_pkg::CTRL_SEQ_BIT];
  wire [2:0] eff_osr   = cfg.hw_mode ? cfg.osr : ctrl_reg[amc_pkg::CTRL_OSR_LSB +: 3];
  wire [2:0] eff_pair  = cfg.hw_mode ? pair_s : ctrl_reg[amc_pkg::CTRL_PAIR_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // register port
  wire regs_live  = !shutdown && !cfg.hw_mode;
  wire wr_ok      = reg_wr && regs_live;
  wire refuse     = (reg_wr || reg_rd) && !regs_live;
  wire [15:0] status_word = {9'h000, active_pair, cfg.hw_mode, shutdown, busy, 1'b0};
  wire [15:0] config_word = {5'h00, cfg.osr, cfg.sequencer, cfg.burst, cfg.check_code,
                             cfg.ref_internal, cfg.single_wire, cfg.iface, cfg.hw_mode};
  logic [15:0] read_mux;

  always_comb begin
    read_mux = 16'h0000;
    unique case (reg_addr)
      amc_pkg::ADDR_CTRL:    read_mux = ctrl_reg;
      amc_pkg::ADDR_STATUS:  read_mux = status_word;
      amc_pkg::ADDR_CONFIG:  read_mux = config_word;
      amc_pkg::ADDR_SCRATCH: read_mux = scratch;
      default:               read_mux = 16'h0000;
    endcase
  end

  // writes; cleared on shutdown, kept over a partial reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= amc_pkg::CTRL_RESET;
      scratch  <= amc_pkg::SCRATCH_RESET;
    end else if (shutdown) begin
      ctrl_reg <= amc_pkg::CTRL_RESET;
      scratch  <= amc_pkg::SCRATCH_RESET;
    end else if (wr_ok && reg_addr == amc_pkg::ADDR_CTRL) begin
      ctrl_reg <= reg_wdata;
    end else if (wr_ok && reg_addr == amc_pkg::ADDR_SCRATCH) begin
      scratch <= reg_wdata;
    end
  end

  // read data one cycle later; status is always readable for diagnosis
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata      <= 16'h0000;
      access_refused <= 1'b0;
    end else begin
      reg_rdata      <= (reg_rd && (regs_live || reg_addr == amc_pkg::ADDR_STATUS))
                        ? read_mux : 16'h0000;
      access_refused <= refuse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  amc_state_e state;
  amc_state_e next_state;
  logic [7:0]  cyc_cnt;
  logic [7:0]  os_cnt;
  logic [2:0]  pair_last;
  wire  trig_rise  = trig_s && !trig_q;
  wire  can_start  = state == AMC_IDLE && !shutdown && rst_pin_s;
  wire  start      = trig_rise && can_start;
  wire  cyc_end    = cyc_cnt == 8'(CONV_CYCLES - 1);
  wire  os_end     = os_cnt == (8'h01 << eff_osr) - 8'h01;
  wire  result     = state == AMC_CONV && cyc_end && os_end;
  wire  more_burst = eff_burst && active_pair != pair_last;
  wire  in_reset   = !rst_pin_s;

  always_comb begin
    next_state = state;
    unique case (state)
      AMC_IDLE: if (start) next_state = AMC_CONV;
      AMC_CONV: if (result && !more_burst) next_state = AMC_DONE;
      AMC_DONE: next_state = AMC_IDLE;
    endcase
    if (in_reset)
      next_state = AMC_IDLE;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      state <= AMC_IDLE;
    else
      state <= next_state;
  end

  // cycle and oversample counters, channel stepping
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_cnt     <= '0;
      os_cnt      <= '0;
      active_pair <= 3'h0;
      pair_last   <= 3'h0;
    end else if (in_reset || start) begin
      cyc_cnt     <= '0;
      os_cnt      <= '0;
      active_pair <= eff_burst ? 3'h0 : eff_pair;
      pair_last   <= eff_pair;
    end else if (state == AMC_CONV) begin
      cyc_cnt <= cyc_end ? 8'h00 : cyc_cnt + 8'h01;
      if (cyc_end)
        os_cnt <= os_end ? 8'h00 : os_cnt + 8'h01;
      if (result && more_burst)
        active_pair <= active_pair + 3'h1;
      else if (result && eff_seq && !eff_burst)
        active_pair <= active_pair + 3'h1;
    end
  end

  // busy high from start until results latched; whole burst sequence
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy          <= 1'b0;
      result_strobe <= 1'b0;
    end else begin
      result_strobe <= result && !in_reset;
      if (in_reset)
        busy <= 1'b0;
      else if (start)
        busy <= 1'b1;
      else if (result && !more_burst)
        busy <= 1'b0;
    end
  end

  // mode, interface and live range outputs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hw_mode      <= 1'b0;
      iface_type   <= 2'h0;
      analog_range <= 2'h0;
    end else begin
      hw_mode      <= cfg.hw_mode;
      iface_type   <= cfg.iface;
      analog_range <= cfg.hw_mode ? strap_s.range_mode : 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  busy_rise_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    start |=> busy) else $error("busy did not rise after start");
  ignore_trig_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    busy && trig_rise |=> $stable(active_pair) || result_strobe || !rst_pin_s)
    else $error("trigger while busy changed pair");
  hw_refuse_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    cfg.hw_mode && reg_wr |=> ($stable(ctrl_reg) && $stable(scratch)) || shutdown)
    else $error("register written in hardware mode");
  mode_fixed_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !full_rel |=> $stable(cfg)) else $error("config changed without full reset");
  shutdown_entry_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(rst_pin_s) ##1 !rst_pin_s [*8] |-> ##24 (shutdown || rst_pin_s))
    else $error("shutdown not entered");
  clear_regs_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    shutdown |=> ctrl_reg == amc_pkg::CTRL_RESET) else $error("registers not cleared");
  hw_decode_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    full_rel |=> cfg.hw_mode == ($past(strap_s.range_mode) != 2'h0))
    else $error("mode decode wrong");
  iface_decode_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    full_rel && !strap_s.iface_sel |=> cfg.iface == amc_pkg::AMC_IF_PARALLEL)
    else $error("interface decode wrong");
  burst_pin_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    full_rel |=> cfg.burst == ($past(strap_hw) && $past(strap_s.burst_wr)))
    else $error("burst strap wrong");
  one_result_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    result_strobe && !eff_burst |=> !result_strobe) else $error("double result");
  range_live_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    cfg.hw_mode |=> analog_range == $past(strap_s.range_mode))
    else $error("range not applied");
  partial_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    partial_rel && !reg_wr |=> !shutdown && $stable(ctrl_reg) && $stable(cfg))
    else $error("partial reset cleared state");

  conv_done_c: cover property (@(posedge core_clk) disable iff (!reset_n) result_strobe);
  burst_seq_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    result_strobe && busy);
  shutdown_exit_c: cover property (@(posedge core_clk) disable iff (!reset_n) full_rel);
  partial_c: cover property (@(posedge core_clk) disable iff (!reset_n) partial_rel);
endmodule : amc_ctrl
`default_nettype wire

// ==== hw/amc_pkg.sv ====
// shared constants and carriers for the converter mode and pin configuration block
package amc_pkg;

  // register map (offsets chosen for this block, word index = offset)
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_STATUS    = 4'h1;
  localparam logic [3:0] ADDR_CONFIG    = 4'h2;
  localparam logic [3:0] ADDR_SCRATCH   = 4'h3;

  // ctrl register fields (software mode only)
  localparam int CTRL_OSR_LSB   = 0;
  localparam int CTRL_BURST_BIT = 3;
  localparam int CTRL_SEQ_BIT   = 4;
  localparam int CTRL_CHK_BIT   = 5;
  localparam int CTRL_PAIR_LSB  = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;

  // timing at 25 MHz
  localparam int CLK_PERIOD_NS      = 40;
  localparam int FULL_RESET_NS      = 1200;
  localparam int PARTIAL_MIN_NS     = 40;
  localparam int FULL_RESET_CYCLES  = (FULL_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PARTIAL_MIN_CYCLES = (PARTIAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYCLES        = 20;
  localparam int PAIR_COUNT         = 8;

  typedef enum logic [1:0] {
    AMC_IF_PARALLEL = 2'h0,
    AMC_IF_SERIAL   = 2'h1,
    AMC_IF_BYTE     = 2'h3
  } amc_iface_e;

  // configuration in force, latched from the straps at full reset release
  typedef struct packed {
    logic       hw_mode;
    amc_iface_e iface;
    logic       single_wire;
    logic       ref_internal;
    logic       check_code;
    logic       burst;
    logic       sequencer;
    logic [2:0] osr;
  } amc_cfg_s;

  // strap pin levels
  typedef struct packed {
    logic [1:0] range_mode;
    logic       iface_sel;
    logic       byte_sel;
    logic       single_wire;
    logic       ref_sel;
    logic       check_code;
    logic       burst_wr;
    logic       sequencer;
    logic [2:0] osr;
  } amc_strap_s;

endpackage : amc_pkg

// ==== hw/amc_sync.sv ====
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module amc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage;

  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage    <= '0;
      sync_out <= '0;
    end else begin
      stage    <= async_in;
      sync_out <= stage;
    end
  end
endmodule : amc_sync
`default_nettype wire
